/* inc/tbo_pkg.sv */
// Purpose: constants for the timer buffer, output and trigger logic
// Assumes: 16-bit counters, two channels
// Notes: field codes and reset values live here
package tbo_pkg;
  localparam int unsigned TBO_WIDTH = 16;
  localparam logic [15:0] TBO_ZERO = 16'h0000;
  localparam logic [15:0] TBO_ONES = 16'hFFFF;
  // ----------------------------------------
  // mode and field encodings
  // ----------------------------------------
  localparam logic [2:0] TBO_CLR_ON_A = 3'h1;
  localparam logic [2:0] TBO_IO_TOGGLE = 3'h3;
  localparam logic [3:0] TBO_IO_CD_TOGGLE = 4'h3;
  localparam logic [3:0] TBO_IO_CD_TOGGLE_MASK = 4'hB;
  localparam logic [3:0] TBO_IO_D_EVCAP = 4'hD;
  localparam logic [1:0] TBO_EVOP_NONE = 2'h0;
  localparam logic [1:0] TBO_EVOP_START = 2'h1;
  localparam logic [1:0] TBO_EVOP_COUNT = 2'h2;
  localparam logic [1:0] TBO_EVOP_CAPTURE = 2'h3;
  localparam int unsigned TBO_FILT_DEPTH = 3;
  localparam logic [1:0] TBO_FILT_RST = 2'h0;
  typedef enum logic [3:0] {
    TBO_MODE_NORMAL = 4'b0001,
    TBO_MODE_RSPWM = 4'b0010,
    TBO_MODE_CPWM = 4'b0100,
    TBO_MODE_PWM = 4'b1000
  } tbo_mode_e;
endpackage

/* logic/tbo_core.sv */
// Purpose: buffer transfer, output control, input filter and event link of a 2-channel timer
// Assumes: one clock, counters and compare events provided by the basic counter logic
// Notes: all control bits are plain ports
`timescale 1ns/10ps
// Overview of operation
// - reset-sync PWM: buffers copy into general regs on channel 0 match A
// - buffered compare: match A toggles pin A and reloads reg A from buffer
// - buffered capture A: counter into reg A, old reg A into buffer C
// - complementary PWM: D0 to B0 on A0 match and/or ch1 underflow per combine bits
// - complementary PWM: D0 >= A0 transfers only on ch1 underflow
// - complementary PWM: D0 zero transfers on A0 match
// - master disable stops timer outputs; port registers then drive pins
// - low on disable input pin sets master disable bit
// - reset-sync or complementary PWM: level select bits invert pins A and B
// - PWM mode: polarity bits B, C, D invert their pins
// - capture inputs pass a three-latch filter on a selectable sampling clock
// - filter output sets when all three latches are high, holds when all are low, clears when they disagree
// - reroute bits OR match C onto pin A, match D onto pin B
// - clear code 001 clears counter 0 on match A0; code 011 toggles on match
// - C or D field 0X11 toggles pin A or B on match C or D
// - complementary PWM trigger on A0 match or ch1 underflow by edge bit
// - event start sets run bits; no effect when already running
// - event count increments counter regardless of prescaler
// - event capture copies counter into reg D; software sets D field 1101 first
// - event operations selectable per channel
// - interrupt request when a flag and its enable are both 1
// - reg A pairs with buffer C, reg B with buffer D
module tbo_core
  import tbo_pkg::*;
#(
  parameter int unsigned W = TBO_WIDTH
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tbo_mode_e mode_i,
  input wire logic combine_mode_bit0_i,
  input wire logic combine_mode_bit1_i,
  input wire logic [1:0] buffer_en_a_i,
  input wire logic [1:0] buffer_en_b_i,
  input wire logic [1:0] capture_mode_a_i,
  input wire logic [1:0] match_a_i,
  input wire logic [1:0] match_b_i,
  input wire logic [1:0] match_c_i,
  input wire logic [1:0] match_d_i,
  input wire logic [1:0] underflow_i,
  input wire logic [1:0] overflow_i,
  input wire logic [2*W-1:0] timer_count_i,
  input wire logic [2*W-1:0] gr_wdata_i,
  input wire logic [2*4-1:0] gr_we_i,
  input wire logic [2*3-1:0] counter_clear_select_i,
  input wire logic [2*3-1:0] a_output_control_i,
  input wire logic [2*3-1:0] b_output_control_i,
  input wire logic [2*4-1:0] c_output_control_i,
  input wire logic [2*4-1:0] d_output_control_i,
  input wire logic omd_set_i,
  input wire logic omd_clr_i,
  input wire logic output_disable_input_sel_i,
  input wire logic output_disable_input_i,
  input wire logic level_select_hi_i,
  input wire logic level_select_lo_i,
  input wire logic polarity_b_i,
  input wire logic polarity_c_i,
  input wire logic polarity_d_i,
  input wire logic [3:0] port_direction_reg_i,
  input wire logic [3:0] port_data_reg_i,
  input wire logic [1:0] filter_en_i,
  input wire logic filter_clock_sel_hi_i,
  input wire logic filter_clock_sel_lo_i,
  input wire logic [3:0] filter_div_en_i,
  input wire logic [2*4-1:0] capture_pin_i,
  input wire logic adc_trigger_enable_i,
  input wire logic adc_trigger_edge_i,
  input wire logic [2*4-1:0] adc_trigger_control_reg_i,
  input wire logic [2*2-1:0] event_op_sel_i,
  input wire logic [1:0] event_i,
  input wire logic [1:0] run_clr_i,
  input wire logic [2*4-1:0] flag_i,
  input wire logic [2*4-1:0] irq_enable_i,
  output logic [2*W-1:0] general_reg_a_o,
  output logic [2*W-1:0] general_reg_b_o,
  output logic [2*W-1:0] general_reg_c_o,
  output logic [2*W-1:0] general_reg_d_o,
  output logic [1:0] counter_clear_o,
  output logic [1:0] counter_run_bit_o,
  output logic [1:0] event_count_o,
  output logic [1:0] capture_a_o,
  output logic [1:0] capture_d_o,
  output logic output_master_disable_reg_o,
  output logic [2*4-1:0] pin_out_o,
  output logic [2*4-1:0] pin_oe_o,
  output logic [2*4-1:0] filtered_pin_o,
  output logic adc_start_o,
  output logic irq_o
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [7:0] cap_meta_reg;
  logic [7:0] cap_sync_reg;
  logic [1:0] odi_meta_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cap_meta_reg <= 8'h00;
      cap_sync_reg <= 8'h00;
      odi_meta_reg <= 2'h3;
    end
    else
    begin
      cap_meta_reg <= capture_pin_i;
      cap_sync_reg <= cap_meta_reg;
      odi_meta_reg <= {odi_meta_reg[0], output_disable_input_i};
    end
  end
  // ----------------------------------------
  // digital filter
  // ----------------------------------------
  logic filt_tick;
  logic [1:0] fsel;
  logic [7:0] lat0_reg, lat1_reg, lat2_reg, filt_reg;
  assign fsel = {filter_clock_sel_hi_i, filter_clock_sel_lo_i};
  assign filt_tick = filter_div_en_i[fsel];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lat0_reg <= 8'h00;
      lat1_reg <= 8'h00;
      lat2_reg <= 8'h00;
      filt_reg <= 8'h00;
    end
    else if (filt_tick)
    begin
      lat0_reg <= cap_sync_reg;
      lat1_reg <= lat0_reg;
      lat2_reg <= lat1_reg;
      filt_reg <= (filt_reg & ~(lat0_reg ^ lat1_reg | lat1_reg ^ lat2_reg))
        | (lat2_reg & ~(lat0_reg ^ lat1_reg | lat1_reg ^ lat2_reg));
    end
  end
  assign filtered_pin_o = filt_reg;
  // ----------------------------------------
  // output master disable
  // ----------------------------------------
  logic omd_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      omd_reg <= 1'b0;
    else if (omd_set_i || (output_disable_input_sel_i && !odi_meta_reg[1]))
      omd_reg <= 1'b1;
    else if (omd_clr_i)
      omd_reg <= 1'b0;
  end
  assign output_master_disable_reg_o = omd_reg;
  // ----------------------------------------
  // per channel logic
  // ----------------------------------------
  logic [1:0] run_reg;
  logic [7:0] pin_reg;
  logic [7:0] pin_mux;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      logic [W-1:0] ga, gb, gc, gd, cnt;
      logic [1:0] evop;
      logic cpwm_a, cpwm_u, tog_a, tog_b, tog_c, tog_d, buf_ev_a, buf_ev_b, cap_a, cap_d;
      logic use_a, use_u;
      assign cnt = timer_count_i[ch*W +: W];
      assign evop = event_op_sel_i[ch*2 +: 2];
      assign cap_a = capture_mode_a_i[ch]
        & (filter_en_i[ch] ? filt_reg[ch*4] : cap_sync_reg[ch*4]);
      assign cap_d = (event_i[ch] && evop == TBO_EVOP_CAPTURE
        && d_output_control_i[ch*4 +: 4] == TBO_IO_D_EVCAP);
      assign cpwm_a = match_a_i[0];
      assign cpwm_u = underflow_i[1];
      always_comb
      begin
        use_a = combine_mode_bit0_i;
        use_u = combine_mode_bit1_i;
        if (gd >= ga)
        begin
          use_a = 1'b0;
          use_u = 1'b1;
        end
        if (gd == TBO_ZERO)
        begin
          use_a = 1'b1;
          use_u = 1'b0;
        end
      end
      always_comb
      begin
        buf_ev_a = 1'b0;
        buf_ev_b = 1'b0;
        case (mode_i)
          TBO_MODE_RSPWM:
          begin
            buf_ev_a = match_a_i[0];
            buf_ev_b = match_a_i[0];
          end
          TBO_MODE_CPWM:
            buf_ev_b = (ch == 0) && ((use_a && cpwm_a) || (use_u && cpwm_u));
          TBO_MODE_PWM, TBO_MODE_NORMAL:
          begin
            buf_ev_a = match_a_i[ch] && !capture_mode_a_i[ch];
            buf_ev_b = match_b_i[ch];
          end
          default:
          begin
            buf_ev_a = 1'b0;
            buf_ev_b = 1'b0;
          end
        endcase
      end
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          ga <= TBO_ONES;
          gb <= TBO_ONES;
          gc <= TBO_ONES;
          gd <= TBO_ONES;
        end
        else
        begin
          if (cap_a)
          begin
            ga <= cnt;
            if (buffer_en_a_i[ch])
              gc <= ga;
          end
          else if (buf_ev_a && buffer_en_a_i[ch])
            ga <= gc;
          else if (gr_we_i[ch*4])
            ga <= gr_wdata_i[ch*W +: W];
          if (buf_ev_b && buffer_en_b_i[ch])
            gb <= gd;
          else if (gr_we_i[ch*4+1])
            gb <= gr_wdata_i[ch*W +: W];
          if (!(cap_a && buffer_en_a_i[ch]) && gr_we_i[ch*4+2])
            gc <= gr_wdata_i[ch*W +: W];
          if (cap_d)
            gd <= cnt;
          else if (gr_we_i[ch*4+3])
            gd <= gr_wdata_i[ch*W +: W];
        end
      end
      assign general_reg_a_o[ch*W +: W] = ga;
      assign general_reg_b_o[ch*W +: W] = gb;
      assign general_reg_c_o[ch*W +: W] = gc;
      assign general_reg_d_o[ch*W +: W] = gd;
      assign capture_a_o[ch] = cap_a;
      assign capture_d_o[ch] = cap_d;
      assign counter_clear_o[ch] = (counter_clear_select_i[ch*3 +: 3] == TBO_CLR_ON_A)
        && match_a_i[ch];
      assign event_count_o[ch] = event_i[ch] && evop == TBO_EVOP_COUNT;
      assign tog_a = (a_output_control_i[ch*3 +: 3] == TBO_IO_TOGGLE) && match_a_i[ch];
      assign tog_b = (b_output_control_i[ch*3 +: 3] == TBO_IO_TOGGLE) && match_b_i[ch];
      // bit 3 picks the pin, bit 2 is a don't-care of the toggle code
      assign tog_c = ((c_output_control_i[ch*4 +: 3] & TBO_IO_CD_TOGGLE_MASK[2:0])
        == TBO_IO_CD_TOGGLE[2:0]) && match_c_i[ch];
      assign tog_d = ((d_output_control_i[ch*4 +: 3] & TBO_IO_CD_TOGGLE_MASK[2:0])
        == TBO_IO_CD_TOGGLE[2:0]) && match_d_i[ch];
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          pin_reg[ch*4 +: 4] <= 4'h0;
        else
        begin
          // pin-select bit clear ORs C onto A and D onto B
          if (tog_a || (!c_output_control_i[ch*4+3] && tog_c))
            pin_reg[ch*4] <= ~pin_reg[ch*4];
          if (tog_b || (!d_output_control_i[ch*4+3] && tog_d))
            pin_reg[ch*4+1] <= ~pin_reg[ch*4+1];
          if (c_output_control_i[ch*4+3] && tog_c)
            pin_reg[ch*4+2] <= ~pin_reg[ch*4+2];
          if (d_output_control_i[ch*4+3] && tog_d)
            pin_reg[ch*4+3] <= ~pin_reg[ch*4+3];
        end
      end
      always_comb
      begin
        pin_mux[ch*4 +: 4] = pin_reg[ch*4 +: 4];
        if (mode_i == TBO_MODE_RSPWM || mode_i == TBO_MODE_CPWM)
        begin
          pin_mux[ch*4] = pin_reg[ch*4] ^ level_select_lo_i;
          pin_mux[ch*4+1] = pin_reg[ch*4+1] ^ level_select_hi_i;
        end
        else if (mode_i == TBO_MODE_PWM)
        begin
          pin_mux[ch*4+1] = pin_reg[ch*4+1] ^ polarity_b_i;
          pin_mux[ch*4+2] = pin_reg[ch*4+2] ^ polarity_c_i;
          pin_mux[ch*4+3] = pin_reg[ch*4+3] ^ polarity_d_i;
        end
      end
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          run_reg[ch] <= 1'b0;
        else if (event_i[ch] && evop == TBO_EVOP_START && !run_reg[ch])
          run_reg[ch] <= 1'b1;
        else if (run_clr_i[ch])
          run_reg[ch] <= 1'b0;
      end
    end
  endgenerate
  assign counter_run_bit_o = run_reg;
  // ----------------------------------------
  // pin drive and triggers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_out_o <= 8'h00;
      pin_oe_o <= 8'h00;
    end
    else
    begin
      pin_out_o <= omd_reg ? {2{port_data_reg_i}} : pin_mux;
      pin_oe_o <= omd_reg ? {2{port_direction_reg_i}} : 8'hFF;
    end
  end
  logic adc_next;
  assign adc_next = (mode_i == TBO_MODE_CPWM && adc_trigger_enable_i)
    ? (adc_trigger_edge_i ? underflow_i[1] : match_a_i[0])
    : |(adc_trigger_control_reg_i & {match_d_i[1], match_c_i[1], match_b_i[1], match_a_i[1],
      match_d_i[0], match_c_i[0], match_b_i[0], match_a_i[0]});
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adc_start_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      adc_start_o <= adc_next;
      irq_o <= |(flag_i & irq_enable_i);
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_evstart;
    @(posedge clk_i) disable iff (rst_i)
    (event_i[0] && event_op_sel_i[1:0] == TBO_EVOP_START) |=> counter_run_bit_o[0];
  endproperty
  a_evstart: assert property (p_evstart) else $error("event start lost");
  property p_omd;
    @(posedge clk_i) disable iff (rst_i)
    omd_set_i |=> output_master_disable_reg_o ##1 (pin_oe_o == {2{$past(port_direction_reg_i)}});
  endproperty
  a_omd: assert property (p_omd) else $error("disable not applied");
  property p_odi;
    @(posedge clk_i) disable iff (rst_i)
    (output_disable_input_sel_i && !output_disable_input_i)[*3] |=> output_master_disable_reg_o;
  endproperty
  a_odi: assert property (p_odi) else $error("disable pin ignored");
  property p_cap;
    @(posedge clk_i) disable iff (rst_i)
    capture_a_o[0] && buffer_en_a_i[0] |=> general_reg_c_o[W-1:0] == $past(general_reg_a_o[W-1:0]);
  endproperty
  a_cap: assert property (p_cap) else $error("capture buffer wrong");
  property p_evcap;
    @(posedge clk_i) disable iff (rst_i)
    capture_d_o[0] |=> general_reg_d_o[W-1:0] == $past(timer_count_i[W-1:0]);
  endproperty
  a_evcap: assert property (p_evcap) else $error("event capture wrong");
  property p_adc;
    @(posedge clk_i) disable iff (rst_i)
    (mode_i == TBO_MODE_CPWM && adc_trigger_enable_i && !adc_trigger_edge_i && match_a_i[0])
      |=> adc_start_o;
  endproperty
  a_adc: assert property (p_adc) else $error("adc trigger missing");
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    |(flag_i & irq_enable_i) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_clr;
    @(posedge clk_i) disable iff (rst_i)
    counter_clear_o[0] |-> match_a_i[0] && counter_clear_select_i[2:0] == TBO_CLR_ON_A;
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_filt;
    @(posedge clk_i) disable iff (rst_i)
    $changed(filtered_pin_o) |-> $past(filt_tick);
  endproperty
  a_filt: assert property (p_filt) else $error("filter moved off tick");
  c_omd: cover property (@(posedge clk_i) omd_set_i ##1 omd_clr_i);
  c_evcap: cover property (@(posedge clk_i) capture_d_o[0]);
  c_adc: cover property (@(posedge clk_i) adc_start_o);
endmodule

/* bench/tbo_link_model.sv */
// Purpose: event link and converter side of the timer block
// Assumes: events are one-cycle pulses issued one cycle after a request
// Notes: the converter side only counts start pulses
`timescale 1ns/10ps
module tbo_link_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] fire_i,
  input wire logic adc_start_i,
  output logic [1:0] event_o,
  output int unsigned adc_seen_o
);
  // ----------------------------------------
  // event pulses and trigger count
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    event_o <= rst_i ? 2'h0 : fire_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      adc_seen_o <= 0;
    else if (adc_start_i === 1'b1)
      adc_seen_o <= adc_seen_o + 1;
  end
endmodule

/* bench/timer_buffer_output_trigger_logic_tb.sv */
// Purpose: self-checking bench for the timer buffer, output and trigger logic
// Assumes: one 50 MHz clock, plain control ports
// Notes: expected values follow the hand-over timing
`timescale 1ns/10ps
module timer_buffer_output_trigger_logic_tb;
  import tbo_pkg::*;
  // ----------------------------------------
  // stimulus signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tbo_mode_e mode_i = TBO_MODE_NORMAL;
  logic combine_mode_bit0_i = 1'b0;
  logic combine_mode_bit1_i = 1'b0;
  logic [1:0] buffer_en_a_i = 2'h0, buffer_en_b_i = 2'h0, capture_mode_a_i = 2'h0;
  logic [1:0] match_a_i = 2'h0, match_b_i = 2'h0, match_c_i = 2'h0, match_d_i = 2'h0;
  logic [1:0] underflow_i = 2'h0, overflow_i = 2'h0, filter_en_i = 2'h0, run_clr_i = 2'h0;
  logic [31:0] timer_count_i = 32'h0000ABCD, gr_wdata_i = 32'h0;
  logic [7:0] gr_we_i = 8'h0, c_output_control_i = 8'h0, d_output_control_i = 8'h0;
  logic [5:0] counter_clear_select_i = 6'h0, a_output_control_i = 6'h0;
  logic [5:0] b_output_control_i = 6'h0;
  logic omd_set_i = 1'b0, omd_clr_i = 1'b0;
  logic output_disable_input_sel_i = 1'b0, output_disable_input_i = 1'b1;
  logic level_select_hi_i = 1'b0, level_select_lo_i = 1'b0;
  logic polarity_b_i = 1'b0, polarity_c_i = 1'b0, polarity_d_i = 1'b0;
  logic [3:0] port_direction_reg_i = 4'hF, port_data_reg_i = 4'h5, filter_div_en_i = 4'hF;
  logic filter_clock_sel_hi_i = 1'b0, filter_clock_sel_lo_i = 1'b0;
  logic [7:0] capture_pin_i = 8'h0, adc_trigger_control_reg_i = 8'h0;
  logic adc_trigger_enable_i = 1'b0, adc_trigger_edge_i = 1'b0;
  logic [3:0] event_op_sel_i = 4'h0;
  logic [7:0] flag_i = 8'h0, irq_enable_i = 8'h0;
  logic [1:0] fire = 2'h0;
  logic [1:0] event_i;
  int unsigned adc_seen;
  logic [31:0] general_reg_a_o, general_reg_b_o, general_reg_c_o, general_reg_d_o;
  logic [1:0] counter_clear_o, counter_run_bit_o, event_count_o, capture_a_o, capture_d_o;
  logic output_master_disable_reg_o, adc_start_o, irq_o;
  logic [7:0] pin_out_o, pin_oe_o, filtered_pin_o;
  int n_fail = 0;
  int checks_done = 0;
  logic [7:0] p;
  int unsigned n0;
  int k;
  always #10 clk_i = ~clk_i;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  tbo_core tbo_core_i (.clk_i, .rst_i, .mode_i, .combine_mode_bit0_i, .combine_mode_bit1_i,
    .buffer_en_a_i, .buffer_en_b_i, .capture_mode_a_i, .match_a_i, .match_b_i, .match_c_i,
    .match_d_i, .underflow_i, .overflow_i, .timer_count_i, .gr_wdata_i, .gr_we_i,
    .counter_clear_select_i, .a_output_control_i, .b_output_control_i, .c_output_control_i,
    .d_output_control_i, .omd_set_i, .omd_clr_i, .output_disable_input_sel_i,
    .output_disable_input_i, .level_select_hi_i, .level_select_lo_i, .polarity_b_i,
    .polarity_c_i, .polarity_d_i, .port_direction_reg_i, .port_data_reg_i, .filter_en_i,
    .filter_clock_sel_hi_i, .filter_clock_sel_lo_i, .filter_div_en_i, .capture_pin_i,
    .adc_trigger_enable_i, .adc_trigger_edge_i, .adc_trigger_control_reg_i, .event_op_sel_i,
    .event_i, .run_clr_i, .flag_i, .irq_enable_i, .general_reg_a_o, .general_reg_b_o,
    .general_reg_c_o, .general_reg_d_o, .counter_clear_o, .counter_run_bit_o, .event_count_o,
    .capture_a_o, .capture_d_o, .output_master_disable_reg_o, .pin_out_o, .pin_oe_o,
    .filtered_pin_o, .adc_start_o, .irq_o);
  tbo_link_model tbo_link_model_i (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .adc_start_i(adc_start_o), .event_o(event_i), .adc_seen_o(adc_seen));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input int ch, input int r, input logic [15:0] v);
    @(posedge clk_i);
    gr_wdata_i <= {v, v};
    gr_we_i <= 8'(8'h1 << (ch * 4 + r));
    @(posedge clk_i);
    gr_we_i <= 8'h0;
  endtask
  task automatic pulse(input int s, input int ch);
    logic [1:0] b;
    b = 2'(2'h1 << ch);
    @(posedge clk_i);
    case (s)
      0: match_a_i <= b;
      1: match_c_i <= b;
      2: underflow_i <= b;
      3: omd_set_i <= 1'b1;
      4: omd_clr_i <= 1'b1;
      5: fire <= b;
      default: run_clr_i <= b;
    endcase
    @(posedge clk_i);
    {match_a_i, match_c_i, underflow_i, fire, run_clr_i} <= 10'h0;
    {omd_set_i, omd_clr_i} <= 2'h0;
    #1;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    wt(5);
    rst_i <= 1'b0;
    chk(general_reg_a_o, 32'hFFFFFFFF, "reset gr a");
    chk(filtered_pin_o, 8'h00, "reset filter");
    chk({output_master_disable_reg_o, counter_run_bit_o, irq_o}, 4'h0, "reset status");
    buffer_en_a_i <= 2'h1;
    a_output_control_i <= {3'h0, TBO_IO_TOGGLE};
    counter_clear_select_i <= {3'h0, TBO_CLR_ON_A};
    wr(0, 2, 16'h1234);
    wt(1);
    p = pin_out_o;
    @(posedge clk_i);
    match_a_i <= 2'h1;
    #1 chk(counter_clear_o, 2'h1, "clear on match a");
    @(posedge clk_i);
    match_a_i <= 2'h0;
    wt(1);
    chk(general_reg_a_o[15:0], 16'h1234, "buffer c to a");
    chk(pin_out_o[0], !p[0], "pin a toggle");
    c_output_control_i <= {4'h0, TBO_IO_CD_TOGGLE};
    p = pin_out_o;
    pulse(1, 0);
    wt(1);
    chk(pin_out_o[0], !p[0], "match c onto pin a");
    capture_mode_a_i <= 2'h1;
    capture_pin_i <= 8'h01;
    k = 0;
    while (capture_a_o[0] !== 1'b1 && k < 10)
    begin
      wt(1);
      k++;
    end
    chk(capture_a_o, 2'h1, "capture a level");
    wt(1);
    chk(general_reg_a_o[15:0], 16'hABCD, "capture into a");
    chk(general_reg_c_o[15:0], 16'h1234, "old a into c");
    capture_pin_i <= 8'h00;
    wt(8);
    capture_mode_a_i <= 2'h0;
    mode_i <= TBO_MODE_CPWM;
    buffer_en_b_i <= 2'h1;
    combine_mode_bit0_i <= 1'b1;
    wr(0, 0, 16'h0100);
    wr(0, 3, 16'h0050);
    pulse(0, 0);
    chk(general_reg_b_o[15:0], 16'h0050, "d to b on a0 match");
    wr(0, 3, 16'h0200);
    pulse(0, 0);
    chk(general_reg_b_o[15:0], 16'h0050, "d above a0 held");
    pulse(2, 1);
    chk(general_reg_b_o[15:0], 16'h0200, "d above a0 on underflow");
    combine_mode_bit0_i <= 1'b0;
    combine_mode_bit1_i <= 1'b1;
    wr(0, 3, 16'h0070);
    pulse(2, 1);
    chk(general_reg_b_o[15:0], 16'h0070, "d to b on underflow");
    combine_mode_bit1_i <= 1'b0;
    wr(0, 3, 16'h0000);
    pulse(0, 0);
    chk(general_reg_b_o[15:0], 16'h0000, "zero d on a0 match");
    adc_trigger_enable_i <= 1'b1;
    for (int e = 0; e < 2; e++)
    begin
      adc_trigger_edge_i <= e[0];
      n0 = adc_seen;
      pulse(0, 0);
      wt(2);
      chk(adc_seen - n0, e == 0, "trigger on a0 match");
      pulse(2, 1);
      wt(2);
      chk(adc_seen - n0, 1, "trigger on underflow");
    end
    adc_trigger_enable_i <= 1'b0;
    mode_i <= TBO_MODE_RSPWM;
    wr(0, 2, 16'h1111);
    wr(0, 3, 16'h2222);
    pulse(0, 0);
    chk({general_reg_a_o[15:0], general_reg_b_o[15:0]}, 32'h11112222, "rspwm load");
    p = pin_out_o;
    level_select_lo_i <= 1'b1;
    wt(3);
    chk(pin_out_o !== p, 1, "level select inverts");
    mode_i <= TBO_MODE_PWM;
    wt(3);
    p = pin_out_o;
    polarity_b_i <= 1'b1;
    wt(3);
    chk(pin_out_o[1], !p[1], "polarity b inverts");
    mode_i <= TBO_MODE_NORMAL;
    adc_trigger_control_reg_i <= 8'h01;
    n0 = adc_seen;
    pulse(0, 0);
    wt(2);
    chk(adc_seen - n0, 1, "trigger by compare match");
    pulse(3, 0);
    chk(output_master_disable_reg_o, 1'b1, "master disable set");
    wt(2);
    chk({pin_out_o, pin_oe_o}, 16'h55FF, "port levels on pins");
    pulse(4, 0);
    chk(output_master_disable_reg_o, 1'b0, "master disable clear");
    output_disable_input_sel_i <= 1'b1;
    output_disable_input_i <= 1'b0;
    wt(5);
    chk(output_master_disable_reg_o, 1'b1, "low pin sets disable");
    output_disable_input_i <= 1'b1;
    wt(3);
    pulse(4, 0);
    event_op_sel_i <= {TBO_EVOP_COUNT, TBO_EVOP_START};
    pulse(5, 0);
    wt(1);
    chk(counter_run_bit_o, 2'h1, "event start ch0 only");
    pulse(6, 0);
    chk(counter_run_bit_o, 2'h0, "run clear");
    pulse(5, 1);
    chk(event_count_o, 2'h2, "event count ch1");
    d_output_control_i <= {4'h0, TBO_IO_D_EVCAP};
    event_op_sel_i <= {TBO_EVOP_NONE, TBO_EVOP_CAPTURE};
    timer_count_i <= 32'h00005A5A;
    pulse(5, 0);
    chk(capture_d_o, 2'h1, "event capture pulse");
    wt(1);
    chk(general_reg_d_o[15:0], 16'h5A5A, "event capture into d");
    filter_en_i <= 2'h1;
    capture_pin_i <= 8'h02;
    wt(2);
    capture_pin_i <= 8'h00;
    wt(8);
    chk(filtered_pin_o[1], 1'b0, "short pulse rejected");
    capture_pin_i <= 8'h02;
    wt(8);
    chk(filtered_pin_o[1], 1'b1, "long pulse passed");
    flag_i <= 8'h01;
    wt(2);
    chk(irq_o, 1'b0, "flag without enable");
    irq_enable_i <= 8'h01;
    wt(2);
    chk(irq_o, 1'b1, "flag with enable");
    finish_test();
  end
endmodule
